// ===== rtl/adcs_framer.sv
/*
 * Serialiser and framer for two 14-bit sample channels: primary and
 * secondary lane per channel, DDR bit clock, frame marker, pin straps
 * with register override, and a small register port.
 * Assumes samples and sample clock are slow against clk_sys_i; every
 * pin is resynchronised before use; the bench resolves lane enables.
 */
`timescale 1ns/1ns
`include "adcs_consts.svh"

// What this block does
// - test pin high sends fixed pattern 10100110001110 msb first, else samples
// - serial control enable high makes straps ignored, register settings used
// - dual-lane, alignment low: secondary words start half a word later
// - dual-lane, alignment high: both lanes start words together
// - lane count pin low selects dual-lane output
// - lane count pin high sends everything on the primary lane
// - one bit per lane on each bit clock edge, both edges
// - bit clock and frame always driven while powered
// - power-down holds bit clock and frame low
// - frame changes only at word starts and half words, or on power-down
// - primary lane words start at frame rising edge
// - dual-lane, alignment low: secondary words start at frame falling edge
// - single-lane sends consecutive samples on the primary lane
// - dual-lane alternates samples between primary and secondary lanes
// - single-lane leaves secondary lanes undriven
// - power-down holds each data lane at its last level
module adcs_framer
	import adcs_pkg::*;
(
	input  wire logic                    clk_sys_i,                // system clock, 10 MHz
	input  wire logic                    rst_i,                    // async reset, high
	input  wire logic                    sample_clk_i,             // sample clock pin
	input  wire logic [`ADCS_WORD_W-1:0] sample_a_i,               // channel a sample
	input  wire logic [`ADCS_WORD_W-1:0] sample_b_i,               // channel b sample
	input  wire logic                    power_down_i,             // power-down pin
	input  wire logic                    serial_ctrl_en_i,         // register override pin
	input  wire logic                    test_mode_i,              // test pattern strap
	input  wire logic                    word_align_select_i,      // alignment strap
	input  wire logic                    lane_count_select_i,      // 1 = single lane
	input  wire logic [`ADCS_ADDR_W-1:0] reg_addr_i,               // register address
	input  wire logic [`ADCS_DATA_W-1:0] reg_wdata_i,              // register write data
	input  wire logic                    reg_we_i,                 // write strobe
	input  wire logic                    reg_re_i,                 // read strobe
	output logic      [`ADCS_DATA_W-1:0] reg_rdata_o,              // read data, next cycle
	output logic                         bit_clock_out_o,          // DDR bit clock
	output logic                         frame_o,                  // word frame
	output logic                         primary_lane_chan_a_o,    // channel a lane 1
	output logic                         primary_lane_chan_b_o,    // channel b lane 1
	output logic                         secondary_lane_chan_a_o,  // channel a lane 0
	output logic                         secondary_lane_chan_a_oe_o, // lane 0 a enable
	output logic                         secondary_lane_chan_b_o,  // channel b lane 0
	output logic                         secondary_lane_chan_b_oe_o  // lane 0 b enable
);
	import adcs_pkg::*;

	adcs_frm_s               st;
	adcs_frm_s               next_st;
	logic [`ADCS_SYNC_W-1:0] pins;
	logic                    smp_s;
	logic                    pd_s;
	logic                    ser_en_s;
	logic                    eff_test;
	logic                    eff_align;
	logic                    eff_single;
	logic [`ADCS_CNT_W-1:0]  sec_start;

	// every pin crosses two flops first
	adcs_sync u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.async_i   ({sample_b_i, sample_a_i, lane_count_select_i, word_align_select_i,
			test_mode_i, serial_ctrl_en_i, power_down_i, sample_clk_i}),
		.stable_o  (pins)
	);

	assign smp_s    = pins[`ADCS_SY_SMP_CLK];
	assign pd_s     = pins[`ADCS_SY_PDOWN];
	assign ser_en_s = pins[`ADCS_SY_SER_EN];

	always_comb begin
		if (ser_en_s) begin
			eff_test   = st.ctrl_test;
			eff_align  = st.ctrl_align;
			eff_single = st.ctrl_single;
		end else begin
			eff_test   = pins[`ADCS_SY_TEST];
			eff_align  = pins[`ADCS_SY_ALIGN];
			eff_single = pins[`ADCS_SY_LANES];
		end
	end

	// shift one bit out, msb leads
	function automatic adcs_word_t shift_word(input adcs_word_t w);
		shift_word = {w[`ADCS_WORD_W-2:0], 1'b0};
	endfunction : shift_word

	// test pattern replaces the sample when enabled
	function automatic adcs_word_t pick_word(input logic tst, input adcs_word_t smp);
		pick_word = tst ? `ADCS_TEST_PATTERN : smp;
	endfunction : pick_word

	// next-state logic: capture, framing, registers
	always_comb begin
		next_st         = st;
		next_st.sec_new = 1'b0;
		sec_start       = `ADCS_FIRST_BIT;
		// sample capture on synchronised sample clock rise
		next_st.smp_prev = smp_s;
		if (smp_s && !st.smp_prev) begin
			if (st.slot && !st.cfg_single) begin
				next_st.odd_a = pins[`ADCS_SY_DATA_A +: `ADCS_WORD_W];
				next_st.odd_b = pins[`ADCS_SY_DATA_B +: `ADCS_WORD_W];
			end else begin
				next_st.even_a = pins[`ADCS_SY_DATA_A +: `ADCS_WORD_W];
				next_st.even_b = pins[`ADCS_SY_DATA_B +: `ADCS_WORD_W];
			end
			next_st.slot = st.cfg_single ? 1'b0 : ~st.slot;
		end
		unique case (st.state)
			ADCS_RUN: begin
				if (pd_s) begin
					next_st.state = ADCS_PDOWN;
					next_st.bclk  = 1'b0;
					next_st.frame = 1'b0;
					next_st.cnt   = `ADCS_LAST_BIT;
				end else begin
					next_st.bclk = ~st.bclk;
					if (st.cnt == `ADCS_LAST_BIT) begin
						next_st.cnt = `ADCS_FIRST_BIT;
						// settings change only at word starts
						next_st.cfg_test   = eff_test;
						next_st.cfg_single = eff_single;
						next_st.cfg_align  = eff_align && !eff_single;
						next_st.pri_a = pick_word(eff_test, st.even_a);
						next_st.pri_b = pick_word(eff_test, st.even_b);
					end else begin
						next_st.cnt   = st.cnt + 4'h1;
						next_st.pri_a = shift_word(st.pri_a);
						next_st.pri_b = shift_word(st.pri_b);
					end
					// frame high for first half word
					next_st.frame = (next_st.cnt < `ADCS_HALF_WORD);
					sec_start = next_st.cfg_align ? `ADCS_FIRST_BIT : `ADCS_HALF_WORD;
					if (next_st.cfg_single) begin
						next_st.sec_a = '0;
						next_st.sec_b = '0;
					end else if (next_st.cnt == sec_start) begin
						next_st.sec_a   = pick_word(next_st.cfg_test, st.odd_a);
						next_st.sec_b   = pick_word(next_st.cfg_test, st.odd_b);
						next_st.sec_new = 1'b1;
					end else begin
						next_st.sec_a = shift_word(st.sec_a);
						next_st.sec_b = shift_word(st.sec_b);
					end
				end
			end
			ADCS_PDOWN: begin
				if (!pd_s) begin
					next_st.state = ADCS_RUN;
				end
			end
		endcase
		// register writes steer the override settings
		if (reg_we_i && reg_addr_i == `ADCS_REG_CTRL) begin
			next_st.ctrl_test   = reg_wdata_i[`ADCS_CTRL_TEST];
			next_st.ctrl_align  = reg_wdata_i[`ADCS_CTRL_ALIGN];
			next_st.ctrl_single = reg_wdata_i[`ADCS_CTRL_SINGLE];
		end
		// read data stands one cycle, zero otherwise
		next_st.rd_data = '0;
		if (reg_re_i) begin
			unique case (reg_addr_i)
				`ADCS_REG_CTRL: begin
					next_st.rd_data = {5'h00, st.ctrl_single, st.ctrl_align, st.ctrl_test};
				end
				`ADCS_REG_STATUS: begin
					next_st.rd_data = {3'h0, ser_en_s, (st.state == ADCS_PDOWN),
						st.cfg_single, st.cfg_align, st.cfg_test};
				end
				default: begin
					next_st.rd_data = '0;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st       <= '0;
			st.state <= ADCS_RUN;
			st.cnt   <= `ADCS_LAST_BIT;
		end else begin
			st <= next_st;
		end
	end

	assign bit_clock_out_o         = st.bclk;
	assign frame_o                 = st.frame;
	assign primary_lane_chan_a_o   = st.pri_a[`ADCS_WORD_W-1];
	assign primary_lane_chan_b_o   = st.pri_b[`ADCS_WORD_W-1];
	assign secondary_lane_chan_a_o = st.sec_a[`ADCS_WORD_W-1];
	assign secondary_lane_chan_b_o = st.sec_b[`ADCS_WORD_W-1];
	assign secondary_lane_chan_a_oe_o = !st.cfg_single;
	assign secondary_lane_chan_b_oe_o = !st.cfg_single;
	assign reg_rdata_o = st.rd_data;

	// checks of the framing behaviour
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	sequence s_word_start;
		$rose(frame_o) && st.cnt == `ADCS_FIRST_BIT;
	endsequence

	sequence s_dual_stagger;
		!st.cfg_single && !st.cfg_align;
	endsequence

	property p_test_word;
		(s_word_start and st.cfg_test) |-> st.pri_a == `ADCS_TEST_PATTERN
			&& st.pri_b == `ADCS_TEST_PATTERN;
	endproperty
	a_test_word: assert property (p_test_word) else $error("test pattern not loaded");

	property p_override;
		s_word_start |-> ($past(ser_en_s) ? st.cfg_test == $past(st.ctrl_test)
			: st.cfg_test == $past(pins[`ADCS_SY_TEST]));
	endproperty
	a_override: assert property (p_override) else $error("wrong setting source");

	// power-down may cut a word short, so the half-word check stands aside then
	property p_stagger;
		disable iff (rst_i || pd_s)
		(s_word_start and s_dual_stagger) |-> ##7 st.sec_new && $fell(frame_o);
	endproperty
	a_stagger: assert property (p_stagger) else $error("secondary not half word late");

	property p_aligned;
		st.sec_new && !st.cfg_single && st.cfg_align |-> $rose(frame_o);
	endproperty
	a_aligned: assert property (p_aligned) else $error("secondary not aligned");

	property p_single_off;
		st.cfg_single |-> !secondary_lane_chan_a_oe_o && !secondary_lane_chan_b_oe_o
			&& !st.sec_new;
	endproperty
	a_single_off: assert property (p_single_off) else $error("secondary active");

	property p_ddr;
		(st.state == ADCS_RUN && $past(st.state) == ADCS_RUN && !$past(rst_i)) |->
			bit_clock_out_o != $past(bit_clock_out_o);
	endproperty
	a_ddr: assert property (p_ddr) else $error("bit clock missed an edge");

	property p_pd_low;
		st.state == ADCS_PDOWN |-> !bit_clock_out_o && !frame_o;
	endproperty
	a_pd_low: assert property (p_pd_low) else $error("clock or frame high in power-down");

	property p_pd_hold;
		st.state == ADCS_PDOWN |-> $stable(primary_lane_chan_a_o)
			&& $stable(secondary_lane_chan_b_o);
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("lane moved in power-down");

	property p_frame_edges;
		$changed(frame_o) && st.state == ADCS_RUN |->
			st.cnt == `ADCS_FIRST_BIT || st.cnt == `ADCS_HALF_WORD;
	endproperty
	a_frame_edges: assert property (p_frame_edges) else $error("frame off boundary");

	property p_word_len;
		(st.state == ADCS_RUN && st.cnt == `ADCS_LAST_BIT && !pd_s) |=> s_word_start;
	endproperty
	a_word_len: assert property (p_word_len) else $error("word not 14 bits");

	property p_sample_word;
		(s_word_start and !st.cfg_test) |-> st.pri_a == $past(st.even_a);
	endproperty
	a_sample_word: assert property (p_sample_word) else $error("primary sample wrong");

	property p_sec_sample;
		(st.sec_new and !st.cfg_test) |-> st.sec_a == $past(st.odd_a);
	endproperty
	a_sec_sample: assert property (p_sec_sample) else $error("secondary sample wrong");

endmodule : adcs_framer

// ===== include/adcs_consts.svh
/*
 * Constants of the serial output framer: word geometry, test pattern,
 * register offsets, field positions, reset values and the layout of the
 * synchronised pin vector.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

// word geometry: one bit per system clock, so one word is 14 cycles
`define ADCS_WORD_W        14
`define ADCS_CNT_W         4
`define ADCS_FIRST_BIT     4'h0
`define ADCS_HALF_WORD     4'h7
`define ADCS_LAST_BIT      4'hd
`define ADCS_TEST_PATTERN  14'h298e

// register port
`define ADCS_ADDR_W        8
`define ADCS_DATA_W        8
`define ADCS_REG_CTRL      8'h00
`define ADCS_REG_STATUS    8'h04
`define ADCS_CTRL_RESET    3'h0
`define ADCS_CTRL_TEST     0
`define ADCS_CTRL_ALIGN    1
`define ADCS_CTRL_SINGLE   2
`define ADCS_STAT_PDOWN    3
`define ADCS_STAT_SER_EN   4

// synchronised pin vector layout
`define ADCS_SYNC_W        34
`define ADCS_SY_SMP_CLK    0
`define ADCS_SY_PDOWN      1
`define ADCS_SY_SER_EN     2
`define ADCS_SY_TEST       3
`define ADCS_SY_ALIGN      4
`define ADCS_SY_LANES      5
`define ADCS_SY_DATA_A     6
`define ADCS_SY_DATA_B     20

`endif

// ===== include/adcs_pkg.sv
/*
 * Types of the serial output framer: state encoding and state records.
 * Assumes adcs_consts.svh is on the include path.
 */
`include "adcs_consts.svh"

package adcs_pkg;

	typedef logic [`ADCS_WORD_W-1:0] adcs_word_t;

	// one-hot framer states
	typedef enum logic [1:0] {
		ADCS_RUN   = 2'b01,
		ADCS_PDOWN = 2'b10
	} adcs_state_e;

	typedef struct packed {
		logic [`ADCS_SYNC_W-1:0] meta;
		logic [`ADCS_SYNC_W-1:0] stable;
	} adcs_sync_s;

	typedef struct packed {
		adcs_state_e             state;
		logic [`ADCS_CNT_W-1:0]  cnt;
		logic                    frame;
		logic                    bclk;
		logic                    sec_new;
		adcs_word_t              pri_a;
		adcs_word_t              pri_b;
		adcs_word_t              sec_a;
		adcs_word_t              sec_b;
		adcs_word_t              even_a;
		adcs_word_t              even_b;
		adcs_word_t              odd_a;
		adcs_word_t              odd_b;
		logic                    slot;
		logic                    smp_prev;
		logic                    cfg_test;
		logic                    cfg_align;
		logic                    cfg_single;
		logic                    ctrl_test;
		logic                    ctrl_align;
		logic                    ctrl_single;
		logic [`ADCS_DATA_W-1:0] rd_data;
	} adcs_frm_s;

endpackage : adcs_pkg

// ===== rtl/adcs_sync.sv
/*
 * Two-flop synchroniser for every pin that reaches the framer.
 * Assumes each bit is a level that stays put for several system clocks.
 */
`timescale 1ns/1ns
`include "adcs_consts.svh"

module adcs_sync
	import adcs_pkg::*;
(
	input  wire logic                    clk_sys_i, // system clock
	input  wire logic                    rst_i,     // async reset, high
	input  wire logic [`ADCS_SYNC_W-1:0] async_i,   // raw pin levels
	output logic      [`ADCS_SYNC_W-1:0] stable_o   // synchronised levels
);
	import adcs_pkg::*;

	adcs_sync_s st;
	adcs_sync_s next_st;

	// meta stage feeds only the stable stage
	always_comb begin
		next_st.meta   = async_i;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign stable_o = st.stable;

endmodule : adcs_sync

// ===== verif/adcs_rx_model.sv
/*
 * Receiving deserialiser for the framer's lanes: rebuilds the last
 * primary and secondary word of each channel from frame edges.
 * Assumes outputs are registered on clk_sys_i, one bit per cycle.
 */
`timescale 1ns/1ns

module adcs_rx_model
	import adcs_pkg::*;
(
	input  wire logic  clk_sys_i,   // system clock
	input  wire logic  frame_i,     // frame marker
	input  wire logic  pri_a_i,     // primary lane a
	input  wire logic  pri_b_i,     // primary lane b
	input  wire logic  sec_a_i,     // secondary lane a
	input  wire logic  sec_b_i,     // secondary lane b
	input  wire logic  aligned_i,   // 1 = secondary starts at rise
	output adcs_word_t pri_a_o,     // last primary word a
	output adcs_word_t pri_b_o,     // last primary word b
	output adcs_word_t sec_a_o,     // last secondary word a
	output adcs_word_t sec_b_o,     // last secondary word b
	output int         words_o      // primary words seen
);
	adcs_word_t sh_pa, sh_pb, sh_sa, sh_sb;
	logic       frame_q = 1'b0;
	int         pcnt    = 15;
	int         scnt    = 15;
	logic       rise, fall;
	int         wcnt    = 0;

	assign words_o = wcnt;

	// msb first: shift every cycle, latch after 14 bits from the start edge
	always @(posedge clk_sys_i) begin
		rise = frame_i && !frame_q;
		fall = !frame_i && frame_q;
		frame_q <= frame_i;
		sh_pa = {sh_pa[12:0], pri_a_i};
		sh_pb = {sh_pb[12:0], pri_b_i};
		sh_sa = {sh_sa[12:0], sec_a_i};
		sh_sb = {sh_sb[12:0], sec_b_i};
		pcnt = rise ? 0 : (pcnt < 15 ? pcnt + 1 : 15);
		scnt = (aligned_i ? rise : fall) ? 0 : (scnt < 15 ? scnt + 1 : 15);
		if (pcnt == 13) begin
			pri_a_o <= sh_pa;
			pri_b_o <= sh_pb;
			wcnt <= wcnt + 1;
		end
		// a misplaced secondary start edge yields a rotated word
		if (scnt == 13) begin
			sec_a_o <= sh_sa;
			sec_b_o <= sh_sb;
		end
	end
endmodule : adcs_rx_model

// ===== verif/adc_serial_lvds_output_framer_tb.sv
/*
 * Self-checking bench of the serial output framer with a receiver model.
 * Assumes a 10 MHz system clock and a 1300 ns sample clock from here.
 */
`timescale 1ns/1ns
`include "adcs_consts.svh"

module adc_serial_lvds_output_framer_tb;
	import adcs_pkg::*;
	logic       clk_sys_i = 0, rst_i = 1, smp_clk = 0, pdown = 0, ser_en = 0;
	logic       test = 0, align = 0, lanes = 0, we = 0, re = 0;
	adcs_word_t smp_a = '0, smp_b = '0, pa, pb, sa, sb;
	logic [7:0] addr = '0, wdata = '0, rdata, rd;
	logic       bclk, frame, lpa, lpb, lsa, lsb, oea, oeb;
	int         words, errors = 0, check_count = 0;

	adcs_framer dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sample_clk_i(smp_clk),
		.sample_a_i(smp_a), .sample_b_i(smp_b), .power_down_i(pdown),
		.serial_ctrl_en_i(ser_en), .test_mode_i(test), .word_align_select_i(align),
		.lane_count_select_i(lanes), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .bit_clock_out_o(bclk),
		.frame_o(frame), .primary_lane_chan_a_o(lpa), .primary_lane_chan_b_o(lpb),
		.secondary_lane_chan_a_o(lsa), .secondary_lane_chan_a_oe_o(oea),
		.secondary_lane_chan_b_o(lsb), .secondary_lane_chan_b_oe_o(oeb));

	adcs_rx_model rx_u (.clk_sys_i(clk_sys_i), .frame_i(frame), .pri_a_i(lpa),
		.pri_b_i(lpb), .sec_a_i(lsa), .sec_b_i(lsb), .aligned_i(align | ser_en),
		.pri_a_o(pa), .pri_b_o(pb), .sec_a_o(sa), .sec_b_o(sb), .words_o(words));

	// 100 ns period system clock
	initial forever #50 clk_sys_i = ~clk_sys_i;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys_i);
		we <= 1'b0;
	endtask : reg_write

	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a);
		@(posedge clk_sys_i);
		re <= 1'b1;
		addr <= a;
		@(posedge clk_sys_i);
		re <= 1'b0;
		#1 rd = rdata;
	endtask : reg_read

	// words latched by the receiver model are the link's own completion marks, bounded wait
	task automatic wait_words(input int n);
		int start, k;
		start = words;
		for (k = 0; k < 40 * n && words < start + n; k++) @(posedge clk_sys_i);
	endtask : wait_words

	// one 1300 ns sample clock period, data steady 4 cycles either side
	task automatic pulse_sample(input adcs_word_t a, input adcs_word_t b);
		@(posedge clk_sys_i);
		smp_a <= a;
		smp_b <= b;
		repeat (4) @(posedge clk_sys_i);
		smp_clk <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		smp_clk <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask : pulse_sample

	task automatic set_pins(input logic t, input logic al, input logic ln);
		@(posedge clk_sys_i);
		test <= t;
		align <= al;
		lanes <= ln;
	endtask : set_pins

	task automatic t_regs;
		reg_read(8'h00);
		check(rd, 16'h0000); // control reset value
		reg_write(8'h04, 8'hff);
		reg_read(8'h04);
		check(rd, 16'h0000); // status read-only
		reg_read(8'h08);
		check(rd, 16'h0000); // unmapped reads zero
		$display("test regs done");
	endtask : t_regs

	task automatic t_framing;
		int i, last, hi;
		logic f0, b0;
		last = -1;
		hi = 0;
		@(posedge clk_sys_i);
		#1 f0 = frame;
		b0 = bclk;
		for (i = 0; i < 42; i++) begin
			@(posedge clk_sys_i);
			#1 check(bclk, !b0); // one bit per clock edge
			if (frame && !f0) begin
				if (last >= 0) check(i - last, 14); // word boundaries
				last = i;
			end
			hi += frame;
			f0 = frame;
			b0 = bclk;
		end
		check(hi, 21); // frame high half a word
		$display("test framing done");
	endtask : t_framing

	task automatic t_pattern;
		set_pins(1'b1, 1'b1, 1'b0);
		wait_words(3);
		check(pa, `ADCS_TEST_PATTERN); // fixed pattern
		check(sb, `ADCS_TEST_PATTERN); // msb first
		set_pins(1'b0, 1'b1, 1'b0);
		pulse_sample(14'h1234, 14'h0abc);
		wait_words(3);
		check(pb, 14'h0abc); // normal data when low
		$display("test pattern done");
	endtask : t_pattern

	task automatic t_single;
		// alignment pin low in single-lane mode
		set_pins(1'b0, 1'b0, 1'b1);
		wait_words(2);
		pulse_sample(14'h3001, 14'h0002);
		pulse_sample(14'h0404, 14'h2808);
		wait_words(3);
		check(pa, 14'h0404); // latest sample on primary
		check(pb, 14'h2808); // primary lane only
		check({oea, oeb}, 2'b00); // secondary undriven
		$display("test single done");
	endtask : t_single

	// settings land first, so the first capture takes the even slot
	task automatic t_dual(input logic al, input adcs_word_t a0, input adcs_word_t b0,
		input adcs_word_t a1, input adcs_word_t b1);
		set_pins(1'b0, al, 1'b0);
		wait_words(2);
		pulse_sample(a0, b0);
		pulse_sample(a1, b1);
		wait_words(4);
		check({oea, oeb}, 2'b11); // dual-lane drives both
		check(pa, a0); // even sample on primary
		check(pb, b0); // primary word from frame rise
		check(sa, a1); // secondary start edge
		check(sb, b1); // odd sample on secondary
		$display("test dual done");
	endtask : t_dual

	task automatic t_override;
		@(posedge clk_sys_i);
		ser_en <= 1'b1;
		set_pins(1'b1, 1'b0, 1'b1);
		reg_write(8'h00, 8'h02);
		wait_words(3);
		check(pa, 14'h0555); // straps ignored
		reg_write(8'h00, 8'h03);
		reg_read(8'h00);
		check(rd, 16'h0003); // control readback
		wait_words(3);
		check(sa, `ADCS_TEST_PATTERN); // register test mode
		reg_read(8'h04);
		check(rd, 16'h0013); // effective settings
		reg_write(8'h00, 8'h04);
		wait_words(2);
		check({oea, oeb}, 2'b00); // register lane count
		reg_read(8'h04);
		check(rd, 16'h0014); // single lane in status
		@(posedge clk_sys_i);
		ser_en <= 1'b0;
		set_pins(1'b0, 1'b0, 1'b0);
		$display("test override done");
	endtask : t_override

	task automatic t_pdown;
		logic [3:0] held;
		int i;
		int w0;
		@(posedge clk_sys_i);
		pdown <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		#1 held = {lpa, lpb, lsa, lsb};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys_i);
			#1 check({bclk, frame}, 2'b00); // clock and frame low
			check({lpa, lpb, lsa, lsb}, held); // lanes hold level
		end
		@(posedge clk_sys_i);
		pdown <= 1'b0;
		w0 = words;
		wait_words(2);
		check(words >= w0 + 2, 1); // outputs run again
		t_framing; // bit clock and frame driven
		$display("test power-down done");
	endtask : t_pdown

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// watchdog well beyond the expected 560 to 720 cycles
	initial begin
		#2000000;
		errors++;
		report_and_stop;
	end

	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		t_regs;
		t_framing;
		t_pattern;
		t_single;
		t_dual(1'b0, 14'h1111, 14'h2222, 14'h0ccc, 14'h3333);
		t_dual(1'b1, 14'h0555, 14'h1aaa, 14'h2468, 14'h1357);
		t_override;
		t_pdown;
		report_and_stop;
	end
endmodule : adc_serial_lvds_output_framer_tb
